//--- design/acc_calib_top.sv
// calibration sequencer, coefficient registers and apb slave of the adc result path
`include "acc_defs.svh"
`default_nettype none

// Operation
// RULE_01 - offset calibration takes one cycle: three outputs chop off, two chop on
// RULE_02 - gain calibration runs two such stages, twice as long as offset calibration
// RULE_03 - a calibration request aborts a running conversion at once
// RULE_04 - calibration runs at the output rate set in the filter configuration
// RULE_05 - after any calibration the converter returns to idle
// RULE_06 - self calibration uses internal zero and internal full-scale inputs
// RULE_07 - system calibration takes its level from the external input, held by the user
// RULE_08 - software loads the unity-gain coefficient before self calibration
// RULE_09 - zero-scale result goes to offset register, full-scale result to gain register
// RULE_10 - offset coefficient is 16-bit two's complement spanning plus or minus one
// RULE_11 - positive offset is subtracted, negative offset magnitude is added
// RULE_12 - offset coefficient zero removes no offset
// RULE_13 - corrected value is multiplied by gain coefficient over 16384
// RULE_14 - nominal gain scales the 0.75 filter span up to full scale
// RULE_15 - result is checked for overflow, then formatted bipolar or unipolar
// RULE_16 - current channel scales offset by k chosen from the gain code
// RULE_17 - low power mode forces gain 128 and k of 32
// RULE_18 - low power plus uses k of 8; half-supply reference doubles k (the code doubles it only in low power and low power plus modes)
// RULE_19 - reset loads the factory unity-gain coefficient
// RULE_20 - user picks gain code of at least one when current sources are on
// RULE_21 - temperature channel current sources follow its control bits 14 to 13
// RULE_22 - system gain span should exceed 40 percent of full scale
// RULE_23 - calibrate at a low output rate to limit noise
// RULE_24 - coefficient writes only when idle; calibrations start through the mode field
// RULE_25 - out of range results clamp to full scale
// RULE_26 - gain estimate is full scale over measured span, saturating
module acc_calib_top #(
   parameter logic [15:0] FACTORY_GAIN = `ACC_GAIN_RST
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic [7:0]              paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    filt_valid,
   input  wire logic signed [23:0]      filt_data,
   output acc_pkg::acc_fe_cmd_type      fe_cmd,
   output logic [15:0]                  filter_config,
   output logic [3:0]                   pga_code,
   output logic [1:0]                   cur_ocs_en,
   output logic [1:0]                   temp_ocs_en,
   output logic                         result_valid,
   output logic [15:0]                  result_data
);
   import acc_pkg::*;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [5:0]          mode_r;
   logic [15:0]         flt_r;
   logic [15:0]         ofs_r;
   logic [15:0]         gain_r;
   logic [15:0]         cctl_r;
   logic [15:0]         tctl_r;
   logic [31:0]         prdata_r;
   acc_state_type       state_r;
   acc_state_type       state_nxt;
   logic [1:0]          cnt_r;
   logic                gain_kind_r;
   logic                self_kind_r;
   logic                abort_r;
   logic signed [23:0]  zero_r;
   logic [15:0]         ofs_meas;
   logic [15:0]         gain_meas;
   logic                ovf;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // zero wait states: read data is captured in the setup cycle
   wire logic acc_ph   = psel & penable;
   wire logic mapped   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   wire logic wr       = acc_ph & pwrite & mapped;
   wire logic wr_mode  = wr && (paddr == `ACC_ADDR_MODE);
   wire logic wr_flt   = wr && (paddr == `ACC_ADDR_FLT);
   wire logic wr_ofs   = wr && (paddr == `ACC_ADDR_OFS);
   wire logic wr_gain  = wr && (paddr == `ACC_ADDR_GAIN);
   wire logic wr_cctl  = wr && (paddr == `ACC_ADDR_CCTL);
   wire logic wr_tctl  = wr && (paddr == `ACC_ADDR_TCTL);
   wire logic cal_req  = wr_mode & pwdata[2]; // RULE_24
   wire logic idle_req = wr_mode && (pwdata[2:0] == `ACC_MD_IDLE);
   wire logic conv_req = wr_mode & ~pwdata[2] & ~idle_req;

   assign pready  = 1'b1;
   assign pslverr = acc_ph & ~mapped;
   assign prdata  = prdata_r;

   // ----------------------------------------
   // sequencer decode
   // ----------------------------------------
   wire logic       chop        = flt_r[`ACC_CHOP_BIT];
   wire logic [1:0] need        = chop ? `ACC_CNT_CHOP_ON : `ACC_CNT_CHOP_OFF; // RULE_01
   wire logic       in_cal      = (state_r == ST_CAL_A) || (state_r == ST_CAL_B);
   wire logic       last        = in_cal && filt_valid && (cnt_r == need - 2'h1);
   wire logic       ofs_done    = last && (state_r == ST_CAL_A) && !gain_kind_r;
   wire logic       gain_done   = last && (state_r == ST_CAL_B); // RULE_02
   wire logic       single_done = (state_r == ST_CONV) && filt_valid && (mode_r[2:0] == `ACC_MD_SINGLE);
   wire logic       hw_idle     = ofs_done | gain_done | single_done; // RULE_05
   wire logic       zero_cap    = last && (state_r == ST_CAL_A) && gain_kind_r;

   // ----------------------------------------
   // offset scale factor
   // ----------------------------------------
   wire logic [1:0] pwr   = mode_r[4:3];
   wire logic       lp    = (pwr == `ACC_PWR_LP);
   wire logic       lpp   = (pwr == `ACC_PWR_LPP);
   wire logic       refh  = cctl_r[`ACC_REFH_BIT];
   wire logic [3:0] pga_n = cctl_r[3:0];
   wire logic [2:0] k_nrm = (pga_n == 4'h1 || pga_n == 4'h7) ? 3'h1 : // RULE_16
                            (pga_n == 4'h8) ? 3'h2 : (pga_n == 4'h9) ? 3'h3 : 3'h0;
   wire logic [2:0] k_sh  = lp ? `ACC_K_LP + {2'h0, refh} : // RULE_17 RULE_18
                            lpp ? `ACC_K_LPP + {2'h0, refh} : k_nrm;

   wire acc_corr_cfg_type corr_cfg = {mode_r[`ACC_UNIP_BIT], k_sh};

   // system gain measures from the stored offset instead of the first stage capture
   wire logic [4:0]         ofs_sh   = `ACC_OFS_ALIGN + {2'h0, k_sh};
   wire logic signed [31:0] sys_zero = 32'($signed(ofs_r)) <<< ofs_sh;
   wire logic signed [23:0] zero_ref = self_kind_r ? zero_r : sys_zero[23:0];

   // ----------------------------------------
   // outputs to front end
   // ----------------------------------------
   assign fe_cmd = {state_r != ST_IDLE, abort_r,
                    self_kind_r && (state_r == ST_CAL_A), // RULE_06 RULE_07
                    self_kind_r && gain_kind_r && (state_r == ST_CAL_B)};
   assign filter_config = flt_r; // RULE_04
   assign pga_code      = lp ? `ACC_PGA_LP : pga_n; // RULE_17
   assign cur_ocs_en    = cctl_r[`ACC_OCS_MSB:`ACC_OCS_LSB];
   assign temp_ocs_en   = tctl_r[`ACC_OCS_MSB:`ACC_OCS_LSB]; // RULE_21

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire logic [31:0] rd_mux =
      (paddr == `ACC_ADDR_MODE) ? {26'h0, mode_r} :
      (paddr == `ACC_ADDR_FLT)  ? {16'h0, flt_r} :
      (paddr == `ACC_ADDR_OFS)  ? {16'h0, ofs_r} :
      (paddr == `ACC_ADDR_GAIN) ? {16'h0, gain_r} :
      (paddr == `ACC_ADDR_CCTL) ? {16'h0, cctl_r} :
      (paddr == `ACC_ADDR_TCTL) ? {16'h0, tctl_r} :
      (paddr == `ACC_ADDR_DATA) ? {16'h0, result_data} :
      (paddr == `ACC_ADDR_STAT) ? {28'h0, state_r, ovf, state_r != ST_IDLE} : 32'h0;

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            state_nxt = ST_IDLE;
         end
         ST_CONV: begin
            if (single_done) state_nxt = ST_IDLE;
         end
         ST_CAL_A: begin
            if (last) state_nxt = gain_kind_r ? ST_CAL_B : ST_IDLE; // RULE_02
         end
         ST_CAL_B: begin
            if (last) state_nxt = ST_IDLE; // RULE_05
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (cal_req) state_nxt = ST_CAL_A; // RULE_03
      else if (conv_req) state_nxt = ST_CONV;
      else if (idle_req) state_nxt = ST_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= ST_IDLE;
         cnt_r       <= 2'h0;
         gain_kind_r <= 1'b0;
         self_kind_r <= 1'b0;
         abort_r     <= 1'b0;
         zero_r      <= 24'h000000;
      end else begin
         state_r <= state_nxt;
         abort_r <= cal_req | idle_req; // RULE_03
         if (cal_req || last) cnt_r <= 2'h0;
         else if (in_cal && filt_valid) cnt_r <= cnt_r + 2'h1;
         if (cal_req) begin
            gain_kind_r <= pwdata[0];
            self_kind_r <= ~pwdata[1];
         end
         if (zero_cap) zero_r <= filt_data; // RULE_06
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // software write in the same cycle as a hardware return to idle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 6'h00;
         flt_r  <= `ACC_FLT_RST;
         cctl_r <= 16'h0000;
         tctl_r <= 16'h0000;
      end else begin
         if (wr_mode) mode_r <= pwdata[5:0];
         else if (hw_idle) mode_r[2:0] <= `ACC_MD_IDLE; // RULE_05
         if (wr_flt) flt_r <= pwdata[15:0];
         if (wr_cctl) cctl_r <= pwdata[15:0];
         if (wr_tctl) tctl_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ofs_r  <= `ACC_OFS_RST;
         gain_r <= FACTORY_GAIN; // RULE_19 RULE_08
      end else begin
         if (wr_ofs && state_r == ST_IDLE) ofs_r <= pwdata[15:0]; // RULE_24
         else if (ofs_done) ofs_r <= ofs_meas; // RULE_09
         if (wr_gain && state_r == ST_IDLE) gain_r <= pwdata[15:0]; // RULE_24
         else if (gain_done) gain_r <= gain_meas; // RULE_09
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_r <= 32'h0;
      else if (psel && !penable && !pwrite) prdata_r <= rd_mux;
   end

   // ----------------------------------------
   // correction datapath
   // ----------------------------------------
   acc_correct u_corr (
      .pclk        (pclk),
      .presetn     (presetn),
      .cfg         (corr_cfg),
      .ofs_coef    (ofs_r),
      .gain_coef   (gain_r),
      .samp_valid  (filt_valid && state_r == ST_CONV),
      .samp        (filt_data),
      .zero_ref    (zero_ref),
      .res_valid_r (result_valid),
      .res_r       (result_data),
      .ovf_r       (ovf),
      .ofs_meas    (ofs_meas),
      .gain_meas   (gain_meas)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [2:0] hv_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hv_cnt_r <= 3'h0;
      else if (cal_req) hv_cnt_r <= 3'h0;
      else if (in_cal && filt_valid) hv_cnt_r <= hv_cnt_r + 3'h1;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OFS_LEN: assert property (ofs_done |-> hv_cnt_r == {1'b0, need} - 3'h1) // RULE_01
      else $error("offset calibration length wrong");
   AST_GAIN_LEN: assert property (gain_done |-> hv_cnt_r == {need, 1'b0} - 3'h1) // RULE_02
      else $error("gain calibration length wrong");
   AST_ABORT: assert property (cal_req |=> state_r == ST_CAL_A && fe_cmd.abort && fe_cmd.run) // RULE_03
      else $error("calibration request did not abort conversion");
   AST_IDLE_AFTER: assert property ((ofs_done || gain_done) && !wr_mode |=> // RULE_05
                                    state_r == ST_IDLE && mode_r[2:0] == `ACC_MD_IDLE && !fe_cmd.run)
      else $error("converter not idle after calibration");
   AST_SELF_SRC: assert property (state_r == ST_CAL_A && self_kind_r |-> fe_cmd.zero_int && !fe_cmd.fs_int) // RULE_06
      else $error("self zero stage not on internal zero");
   AST_SYS_SRC: assert property (in_cal && !self_kind_r |-> !fe_cmd.zero_int && !fe_cmd.fs_int) // RULE_07
      else $error("system calibration not on external input");
   AST_OFS_STORE: assert property (ofs_done && !wr_mode |=> ofs_r == $past(ofs_meas)) // RULE_09
      else $error("offset result not stored");
   AST_GAIN_STORE: assert property (gain_done && !wr_mode |=> gain_r == $past(gain_meas)) // RULE_09
      else $error("gain result not stored");
   AST_COEF_LOCK: assert property (state_r == ST_CONV && (wr_ofs || wr_gain) |=> // RULE_24
                                   $stable(ofs_r) && $stable(gain_r))
      else $error("coefficient written while busy");
   AST_K_LP: assert property (pwr == `ACC_PWR_LP |-> pga_code == 4'h7 && k_sh == 3'h5 + {2'h0, refh}) // RULE_17
      else $error("low power gain or offset scale wrong");

   C_OFS_CAL: cover property (ofs_done);
   C_GAIN_CAL: cover property (gain_done);
   C_ABORT_CONV: cover property (state_r == ST_CONV ##1 state_r == ST_CAL_A);

endmodule

`default_nettype wire

//--- design/acc_defs.svh
// register offsets, field positions, reset values and mode codes of the calibration block
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACC_ADDR_MODE     8'h00
`define ACC_ADDR_FLT      8'h04
`define ACC_ADDR_OFS      8'h08
`define ACC_ADDR_GAIN     8'h0c
`define ACC_ADDR_CCTL     8'h10
`define ACC_ADDR_TCTL     8'h14
`define ACC_ADDR_DATA     8'h18
`define ACC_ADDR_STAT     8'h1c

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACC_FLT_RST       16'h0007
`define ACC_GAIN_RST      16'h5555
`define ACC_OFS_RST       16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACC_CHOP_BIT      15
`define ACC_OCS_MSB       14
`define ACC_OCS_LSB       13
`define ACC_REFH_BIT      12
`define ACC_UNIP_BIT      5

// ----------------------------------------
// mode field codes and power modes
// ----------------------------------------
`define ACC_MD_IDLE       3'h0
`define ACC_MD_CONT       3'h1
`define ACC_MD_SINGLE     3'h2
`define ACC_PWR_LP        2'h1
`define ACC_PWR_LPP       2'h2

// ----------------------------------------
// sequencing and datapath constants
// ----------------------------------------
`define ACC_CNT_CHOP_OFF  2'h3
`define ACC_CNT_CHOP_ON   2'h2
`define ACC_PGA_LP        4'h7
`define ACC_K_LP          3'h5
`define ACC_K_LPP         3'h3
`define ACC_OFS_ALIGN     5'h07
`define ACC_OUT_SHIFT     6'h15
`define ACC_GAIN_UNITY    16'h4000
`define ACC_GAIN_NUM      37'h10_0000_0000

`endif

//--- design/acc_pkg.sv
// types shared by the calibration block
`default_nettype none

package acc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CONV  = 2'h1,
      ST_CAL_A = 2'h3,
      ST_CAL_B = 2'h2
   } acc_state_type;

   typedef struct packed {
      logic run;
      logic abort;
      logic zero_int;
      logic fs_int;
   } acc_fe_cmd_type;

   typedef struct packed {
      logic       unipolar;
      logic [2:0] k_shift;
   } acc_corr_cfg_type;

endpackage

`default_nettype wire

//--- design/acc_correct.sv
// offset and gain correction datapath with clamp and coefficient estimation
`include "acc_defs.svh"
`default_nettype none

module acc_correct (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire acc_pkg::acc_corr_cfg_type cfg,
   input  wire logic [15:0]               ofs_coef,
   input  wire logic [15:0]               gain_coef,
   input  wire logic                      samp_valid,
   input  wire logic signed [23:0]        samp,
   input  wire logic signed [23:0]        zero_ref,
   output logic                           res_valid_r,
   output logic [15:0]                    res_r,
   output logic                           ovf_r,
   output logic [15:0]                    ofs_meas,
   output logic [15:0]                    gain_meas
);
   import acc_pkg::*;

   // ----------------------------------------
   // correction
   // ----------------------------------------
   // offset lsb weighs 2^-15, filter lsb 2^-22: align, then scale by k
   wire logic [4:0]         ofs_sh  = `ACC_OFS_ALIGN + {2'h0, cfg.k_shift};
   wire logic signed [31:0] ofs_ext = 32'($signed(ofs_coef)) <<< ofs_sh; // RULE_10 RULE_16
   wire logic signed [31:0] corr    = 32'(samp) - ofs_ext; // RULE_11 RULE_12
   wire logic signed [48:0] prod    = corr * $signed({1'b0, gain_coef}); // RULE_13 RULE_14
   wire logic signed [48:0] scaled  = prod >>> `ACC_OUT_SHIFT;
   wire logic               pos_ov  = scaled > 49'sd32767; // RULE_15
   wire logic               neg_ov  = scaled < -49'sd32768;
   wire logic [15:0]        clamped = pos_ov ? 16'h7fff : neg_ov ? 16'h8000 : scaled[15:0]; // RULE_25
   wire logic [15:0]        fmt     = cfg.unipolar ? {~clamped[15], clamped[14:0]} : clamped; // RULE_15

   // ----------------------------------------
   // coefficient estimation
   // ----------------------------------------
   wire logic signed [31:0] ofs_raw = 32'(samp) >>> ofs_sh;
   assign ofs_meas = (ofs_raw > 32'sd32767) ? 16'h7fff :
                     (ofs_raw < -32'sd32768) ? 16'h8000 : ofs_raw[15:0];
   // full scale (2^22) over measured span, in units of 2^-14; division is combinational
   wire logic signed [24:0] span    = 25'(samp) - 25'(zero_ref);
   wire logic [36:0]        quot    = `ACC_GAIN_NUM / {12'h0, span};
   assign gain_meas = (span <= 25'sd0 || quot > 37'h0_0000_ffff) ? 16'hffff : quot[15:0]; // RULE_26

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid_r <= 1'b0;
         res_r       <= 16'h0000;
         ovf_r       <= 1'b0;
      end else begin
         res_valid_r <= samp_valid;
         if (samp_valid) begin
            res_r <= fmt;
            ovf_r <= pos_ov | neg_ov;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_CLAMP: assert property (res_valid_r && ovf_r |-> res_r == 16'h7fff || res_r == 16'h8000 || // RULE_25
                               res_r == 16'hffff || res_r == 16'h0000)
      else $error("overflowed result not clamped");
   AST_ZERO_OFS: assert property (samp_valid && ofs_coef == 16'h0000 && gain_coef == `ACC_GAIN_UNITY && // RULE_12
                                  !cfg.unipolar && samp[23] == samp[22] |=> res_r == $past(samp[22:7]))
      else $error("zero offset with unity gain altered the sample");
   C_CLAMP: cover property (res_valid_r && ovf_r);

endmodule

`default_nettype wire

//--- verification/acc_fe_model.sv
// front end model: modulator and decimation filter feeding the result path
`default_nettype none

module acc_fe_model #(
   parameter logic signed [23:0] ZL = 24'sh000a80,
   parameter logic signed [23:0] FL = 24'sh300a80
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire acc_pkg::acc_fe_cmd_type fe_cmd,
   input  wire logic [15:0]             filter_config,
   input  wire logic signed [23:0]      ext_level,
   output logic                         filt_valid,
   output logic signed [23:0]           filt_data
);
   timeunit 1ns;
   timeprecision 100ps;
   import acc_pkg::*;
   logic [7:0] gap_r;
   logic       fire;
   // ----------------------------------------
   // output pacing
   // ----------------------------------------
   // period follows the decimation factor; an abort restarts the filter
   assign fire = fe_cmd.run && !fe_cmd.abort && gap_r == {1'b0, filter_config[6:0]} + 8'h03;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r      <= 8'h00;
         filt_valid <= 1'b0;
         filt_data  <= 24'sh5a5a5a;
      end else begin
         gap_r      <= (!fe_cmd.run || fe_cmd.abort || filt_valid) ? 8'h00 : gap_r + 8'h01;
         filt_valid <= fire;
         // data toggles between outputs so a stale sample never looks valid
         filt_data  <= !fire ? ~filt_data : fe_cmd.zero_int ? ZL : fe_cmd.fs_int ? FL : ext_level;
      end
   end
endmodule

`default_nettype wire

//--- verification/tb_adc_calibration_correction.sv
// self-checking bench of the adc calibration and correction block
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); end end

module tb_adc_calibration_correction;
   timeunit 1ns;
   timeprecision 100ps;
   import acc_pkg::*;
   localparam logic signed [23:0] ZL = 24'sh000a80;
   localparam logic signed [23:0] FL = 24'sh300a80;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, filt_valid, result_valid, rerr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rdat, lfsr;
   logic [15:0]        filter_config, result_data, ofs_cur, gcur;
   logic [3:0]         pga_code;
   logic [1:0]         cur_ocs_en, temp_ocs_en;
   logic signed [23:0] filt_data, ext_level, smp;
   acc_fe_cmd_type     fe_cmd;
   int                 fail_count = 0, checks_done = 0, pulses = 0, aborts = 0, p0, a0;
   // {unipolar, half ref, power, gain code}
   logic [7:0]         cv [10] = '{8'h00, 8'h81, 8'h03, 8'h07, 8'h08, 8'h89, 8'h12, 8'h52, 8'ha4, 8'h64};

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   acc_calib_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .filt_valid(filt_valid), .filt_data(filt_data), .fe_cmd(fe_cmd), .filter_config(filter_config),
      .pga_code(pga_code), .cur_ocs_en(cur_ocs_en), .temp_ocs_en(temp_ocs_en),
      .result_valid(result_valid), .result_data(result_data));
   acc_fe_model #(.ZL(ZL), .FL(FL)) i_fe (.pclk(pclk), .presetn(presetn), .fe_cmd(fe_cmd),
      .filter_config(filter_config), .ext_level(ext_level), .filt_valid(filt_valid), .filt_data(filt_data));

   always @(posedge pclk) begin
      if (fe_cmd.abort === 1'b1) aborts <= aborts + 1;
      if (filt_valid === 1'b1 && fe_cmd.run === 1'b1) pulses <= pulses + 1;
   end

   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   function automatic int ks(input logic [7:0] c);
      if (c[5:4] == 2'h1) return 5 + c[6];
      if (c[5:4] == 2'h2) return 3 + c[6];
      case (c[3:0])
         4'h1, 4'h7: return 1;
         4'h8: return 2;
         4'h9: return 3;
         default: return 0;
      endcase
   endfunction
   function automatic logic [15:0] sat(input longint v);
      return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : 16'(v);
   endfunction
   function automatic logic [15:0] ocal(input longint s, input logic [7:0] c);
      return sat(s >>> (7 + ks(c)));
   endfunction
   function automatic logic [15:0] gcal(input longint span);
      return (span <= 0 || (64'sh10_0000_0000 / span) > 65535) ? 16'hffff : 16'(64'sh10_0000_0000 / span);
   endfunction
   function automatic logic [15:0] conv(input longint f, input logic [15:0] o, g, input logic [7:0] c);
      logic [15:0] r;
      r = sat(((f - (longint'($signed(o)) <<< (7 + ks(c)))) * longint'(g)) >>> 21);
      return {r[15] ^ c[7], r[14:0]};
   endfunction

   // ----------------------------------------
   // bus and sequence tasks
   // ----------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic conv_check(input logic [7:0] c);
      int n;
      n = 0;
      do @(posedge pclk); while (filt_valid !== 1'b1 && ++n < 2000);
      smp = filt_data;
      ext_level <= {{3{lfsr[20]}}, lfsr[20:0]};
      lfsr = nxt(lfsr);
      @(negedge pclk);
      `CHK("result valid", 1'b1, result_valid)
      `CHK("result data", conv(smp, ofs_cur, gcur, c), result_data)
      @(posedge pclk);
   endtask
   task automatic cal(input logic [2:0] md, input logic [7:0] ra, input logic [15:0] ex, input int n);
      int w;
      w = 0;
      p0 = pulses;
      apb(8'h00, 1'b1, {29'h0, md});
      do @(posedge pclk); while (fe_cmd.run !== 1'b0 && ++w < 5000);
      `CHK("cal outputs", n, pulses - p0)
      apb(8'h00, 1'b0, 32'h0);
      `CHK("mode after cal", 3'h0, rdat[2:0])
      apb(ra, 1'b0, 32'h0);
      `CHK("coefficient", ex, rdat[15:0])
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      end_of_test;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ext_level = '0;
      lfsr = 32'h6426;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("filter config", 16'h0007, filter_config)
      `CHK("ready", 1'b1, pready)
      apb(8'h0c, 1'b0, 32'h0);
      `CHK("gain reset", 16'h5555, rdat[15:0])
      apb(8'h08, 1'b0, 32'h0);
      `CHK("offset reset", 16'h0000, rdat[15:0])
      apb(8'h20, 1'b0, 32'h0);
      `CHK("unmapped error", 1'b1, rerr)
      `CHK("unmapped data", 32'h0, rdat)
      $display("reset test done");
      for (int ch = 0; ch < 2; ch++) begin
         apb(8'h04, 1'b1, {16'h0, ch[0], 15'h001f});
         apb(8'h0c, 1'b1, 32'h5555);
         cal(3'h4, 8'h08, ocal(ZL, 8'h00), ch ? 2 : 3);
         cal(3'h5, 8'h0c, gcal(FL - ZL), ch ? 4 : 6);
         smp = {{3{lfsr[20]}}, lfsr[20:0]};
         lfsr = nxt(lfsr);
         ext_level <= smp;
         ofs_cur = ocal(smp, 8'h00);
         cal(3'h6, 8'h08, ofs_cur, ch ? 2 : 3);
         smp = ch ? 24'sh2c0000 : 24'sh280000;
         ext_level <= smp;
         cal(3'h7, 8'h0c, gcal(smp - (longint'($signed(ofs_cur)) <<< 7)), ch ? 4 : 6);
      end
      $display("calibration test done");
      for (int i = 0; i < 10; i++) begin
         ofs_cur = i ? {{7{lfsr[8]}}, lfsr[8:0]} : 16'h0000;
         gcur = i ? lfsr[31:16] : 16'h4000;
         lfsr = nxt(lfsr);
         apb(8'h08, 1'b1, {16'h0, ofs_cur});
         apb(8'h0c, 1'b1, {16'h0, gcur});
         apb(8'h10, 1'b1, {17'h0, cv[i][3:0] != 0 ? lfsr[1:0] : 2'h0, cv[i][6], 8'h0, cv[i][3:0]});
         apb(8'h14, 1'b1, {17'h0, lfsr[3:2], 13'h0});
         `CHK("temp ocs", lfsr[3:2], temp_ocs_en)
         `CHK("cur ocs", cv[i][3:0] != 0 ? lfsr[1:0] : 2'h0, cur_ocs_en)
         apb(8'h00, 1'b1, {26'h0, cv[i][7], cv[i][5:4], 3'h1});
         `CHK("gain code", cv[i][5:4] == 2'h1 ? 4'h7 : cv[i][3:0], pga_code)
         repeat (3) conv_check(cv[i]);
         apb(8'h08, 1'b1, {16'h0, ~ofs_cur});
         apb(8'h00, 1'b1, 32'h0);
         apb(8'h08, 1'b0, 32'h0);
         `CHK("offset kept", ofs_cur, rdat[15:0])
      end
      $display("conversion test done");
      apb(8'h00, 1'b1, 32'h2);
      conv_check(8'h04);
      apb(8'h00, 1'b0, 32'h0);
      `CHK("single mode", 3'h0, rdat[2:0])
      gcur = 16'h5555;
      apb(8'h0c, 1'b1, 32'h5555);
      apb(8'h00, 1'b1, 32'h1);
      conv_check(8'h04);
      a0 = aborts;
      cal(3'h4, 8'h08, ocal(ZL, 8'h04), 2);
      `CHK("abort pulses", 1, aborts - a0)
      $display("abort test done");
      end_of_test;
   end
endmodule

`default_nettype wire
